//--- design/comm_manager_control_regs.sv
// Control and status byte registers of the communication manager
// Assumes an APB master on mclk_i; power manager status arrives from
// another clock domain; address-byte and length-byte write strobes come
// from neighbouring logic on mclk_i.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "comm_ctrl_regs.svh"

module comm_manager_control_regs (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Power manager status, asynchronous to mclk_i
	input wire comm_ctrl_pkg::pm_status_s pm_status_i,
	// Neighbouring register strobes
	input wire logic target_address_second_byte_wr_i,
	input wire logic transfer_length_high_byte_wr_i,
	input wire logic [1:0] transfer_length_low_byte_lsbs_i,
	// Control towards the bus reader and DMA engine
	output logic [1:0] bus_read_trigger_mode_o,
	output logic mem_read_start_o,
	output logic dma_kickoff_o,
	output comm_ctrl_pkg::dma_ctrl_s dma_ctrl_o
);

	// Register state
	logic [1:0] bus_read_trigger_mode_q;
	logic [5:0] general_purpose_bits_q;
	logic [7:0] spare_byte_q;
	logic dma_queue_flush_q;
	logic dma_engine_reset_bit_q;
	logic [7:0] dma_addr0_q;
	logic [7:0] dma_addr1_q;
	logic [7:0] dma_addr2_q;
	comm_ctrl_pkg::pm_status_s pm_status_q;

	// Bus state
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic mapped_d;
	logic [5:0] reg_idx;
	logic access_phase;
	logic wr_commit;
	logic [7:0] wbyte;

	// Outputs towards the engine
	logic mem_read_start_q;
	logic dma_kickoff_q;
	comm_ctrl_pkg::dma_ctrl_s dma_ctrl_q;

	// Synchroniser stages for the power manager status
	logic [7:0] pm_sync1_q;
	logic [7:0] pm_sync2_q;
	logic [7:0] pm_sync3_q;

	assign reg_idx = paddr_i[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
	assign access_phase = psel_i & penable_i;
	assign wbyte = pwdata_i[7:0];

	// Write takes effect only at the edge where the master sees pready
	assign wr_commit = access_phase & pready_q & pwrite_i & pstrb_i[0] &
		mapped_d;

	// Address decode and read mux
	always_comb begin
		mapped_d = 1'b1;
		prdata_d = `ZERO_WORD;
		if (paddr_i[1:0] != `ZERO_BITS2) begin
			mapped_d = 1'b0;
		end else begin
			case (reg_idx)
				`IDX_ACCESS_CTL: begin
					prdata_d[7:0] = {general_purpose_bits_q,
						bus_read_trigger_mode_q};
				end
				`IDX_SPARE_BYTE: begin
					prdata_d[7:0] = spare_byte_q;
				end
				`IDX_GEN_STATUS: begin
					prdata_d[7:0] = pm_status_q;
				end
				`IDX_DMA_DBG_FIFO: begin
					prdata_d[7:0] = {`ZERO_BITS7, dma_queue_flush_q};
				end
				`IDX_DMA_DBG_ENGINE: begin
					prdata_d[7:0] = {`ZERO_BITS7, dma_engine_reset_bit_q};
				end
				`IDX_DMA_ADDR0: begin
					prdata_d[7:0] = dma_addr0_q;
				end
				`IDX_DMA_ADDR1: begin
					prdata_d[7:0] = dma_addr1_q;
				end
				`IDX_DMA_ADDR2: begin
					prdata_d[7:0] = dma_addr2_q;
				end
				default: begin
					mapped_d = 1'b0;
				end
			endcase
		end
	end

	// The access control register shows the fixed depth code on top
	// of the spare bits; software sees the code, writes never touch it
	logic [31:0] prdata_final;
	always_comb begin
		prdata_final = prdata_d;
		if (mapped_d && reg_idx == `IDX_ACCESS_CTL) begin
			prdata_final[7:6] = `REQ_FIFO_DEPTH_CODE;
		end
	end

	// One wait state: pready rises in the second access-phase cycle
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= access_phase & ~pready_q;
		end
	end

	// Read data captured in the first access cycle, shown with pready
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			prdata_q <= `ZERO_WORD;
		end else if (access_phase & ~pready_q & ~pwrite_i) begin
			prdata_q <= prdata_final;
		end else begin
			prdata_q <= `ZERO_WORD;
		end
	end

	// Error for unmapped or unaligned addresses, shown with pready
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			pslverr_q <= 1'b0;
		end else if (access_phase & ~pready_q) begin
			pslverr_q <= ~mapped_d;
		end else begin
			pslverr_q <= 1'b0;
		end
	end

	// Trigger mode of the access control register
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			bus_read_trigger_mode_q <= `RST_TRIGGER_MODE;
		end else if (wr_commit && reg_idx == `IDX_ACCESS_CTL) begin
			bus_read_trigger_mode_q <= wbyte[1:0];
		end
	end

	// Spare bits of the access control register; depth code is fixed
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			general_purpose_bits_q <= `RST_SPARE_BITS;
		end else if (wr_commit && reg_idx == `IDX_ACCESS_CTL) begin
			general_purpose_bits_q <= wbyte[7:2];
		end
	end

	// Spare byte
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			spare_byte_q <= `RST_BYTE;
		end else if (wr_commit && reg_idx == `IDX_SPARE_BYTE) begin
			spare_byte_q <= wbyte;
		end
	end

	// Queue flush bit; upper bits are reserved and not stored
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dma_queue_flush_q <= `RST_BIT;
		end else if (wr_commit && reg_idx == `IDX_DMA_DBG_FIFO) begin
			dma_queue_flush_q <= wbyte[0];
		end
	end

	// Engine reset bit; a level held until software writes zero
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dma_engine_reset_bit_q <= `RST_BIT;
		end else if (wr_commit && reg_idx == `IDX_DMA_DBG_ENGINE) begin
			dma_engine_reset_bit_q <= wbyte[0];
		end
	end

	// DMA start address, low byte
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dma_addr0_q <= `RST_BYTE;
		end else if (wr_commit && reg_idx == `IDX_DMA_ADDR0) begin
			dma_addr0_q <= wbyte;
		end
	end

	// DMA start address, middle byte
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dma_addr1_q <= `RST_BYTE;
		end else if (wr_commit && reg_idx == `IDX_DMA_ADDR1) begin
			dma_addr1_q <= wbyte;
		end
	end

	// DMA start address, high byte
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dma_addr2_q <= `RST_BYTE;
		end else if (wr_commit && reg_idx == `IDX_DMA_ADDR2) begin
			dma_addr2_q <= wbyte;
		end
	end

	// First synchroniser stage; may go metastable, only stage two reads it
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			pm_sync1_q <= `RST_PM_STATUS;
		end else begin
			pm_sync1_q <= pm_status_i;
		end
	end

	// Second synchroniser stage
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			pm_sync2_q <= `RST_PM_STATUS;
		end else begin
			pm_sync2_q <= pm_sync1_q;
		end
	end

	// Third synchroniser stage
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			pm_sync3_q <= `RST_PM_STATUS;
		end else begin
			pm_sync3_q <= pm_sync2_q;
		end
	end

	// Each status bit takes a new value only once stages two and three
	// agree, so a bit caught mid-change is not shown
	comm_ctrl_pkg::pm_status_s pm_status_d;
	always_comb begin
		pm_status_d = pm_status_q;
		for (int i = 0; i < $bits(pm_status_d); i++) begin
			if (pm_sync2_q[i] == pm_sync3_q[i]) begin
				pm_status_d[i] = pm_sync3_q[i];
			end
		end
	end

	// Status mirror; reload request resets clear for a cold start
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			pm_status_q <= `RST_PM_STATUS;
		end else begin
			pm_status_q <= pm_status_d;
		end
	end

	// Automatic memory read unless the trigger mode selects manual
	logic mem_read_start_d;
	always_comb begin
		mem_read_start_d = target_address_second_byte_wr_i &
			(bus_read_trigger_mode_q != `TRIGGER_MODE_MANUAL);
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			mem_read_start_q <= 1'b0;
		end else begin
			mem_read_start_q <= mem_read_start_d;
		end
	end

	// Kick off on high length write unless low bits select no-kick;
	// held off while the engine is in reset
	logic dma_kickoff_d;
	always_comb begin
		dma_kickoff_d = transfer_length_high_byte_wr_i &
			(transfer_length_low_byte_lsbs_i != `LENGTH_LOW_NO_KICK) &
			~dma_engine_reset_bit_q;
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dma_kickoff_q <= 1'b0;
		end else begin
			dma_kickoff_q <= dma_kickoff_d;
		end
	end

	// Engine reset towards the DMA engine
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dma_ctrl_q.dma_engine_reset_bit <= `RST_BIT;
		end else begin
			dma_ctrl_q.dma_engine_reset_bit <= dma_engine_reset_bit_q;
		end
	end

	// Queue flush towards the DMA FIFO
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dma_ctrl_q.dma_queue_flush <= `RST_BIT;
		end else begin
			dma_ctrl_q.dma_queue_flush <= dma_queue_flush_q;
		end
	end

	// Word-aligned start address; the two low bits never reach the engine
	logic [23:0] start_address_d;
	always_comb begin
		start_address_d = {dma_addr2_q, dma_addr1_q,
			dma_addr0_q[7:2], `ZERO_BITS2};
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dma_ctrl_q.start_address <= `RST_ADDR;
		end else begin
			dma_ctrl_q.start_address <= start_address_d;
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign bus_read_trigger_mode_o = bus_read_trigger_mode_q;
	assign mem_read_start_o = mem_read_start_q;
	assign dma_kickoff_o = dma_kickoff_q;
	assign dma_ctrl_o = dma_ctrl_q;

endmodule // comm_manager_control_regs

//--- design/comm_ctrl_regs.svh
// Register indexes, field positions and reset values of the control bank
// Assumes byte address equals four times the register index on the APB side
`ifndef COMM_CTRL_REGS_SVH
`define COMM_CTRL_REGS_SVH

// Register indexes
`define IDX_ACCESS_CTL 6'h30
`define IDX_SPARE_BYTE 6'h31
`define IDX_GEN_STATUS 6'h32
`define IDX_DMA_DBG_FIFO 6'h36
`define IDX_DMA_DBG_ENGINE 6'h37
`define IDX_DMA_ADDR0 6'h38
`define IDX_DMA_ADDR1 6'h39
`define IDX_DMA_ADDR2 6'h3A

// Address split of the APB byte address
`define ADDR_IDX_MSB 7
`define ADDR_IDX_LSB 2

// Field values
`define DEPTH_CODE_4 2'h0
`define DEPTH_CODE_8 2'h1
`define REQ_FIFO_DEPTH_CODE `DEPTH_CODE_4
`define TRIGGER_MODE_MANUAL 2'h3
`define LENGTH_LOW_NO_KICK 2'h2

// Reset values
`define RST_BYTE 8'h00
`define RST_TRIGGER_MODE 2'h0
`define RST_SPARE_BITS 6'h00
`define RST_PM_STATUS 8'hE4
`define RST_BIT 1'h0
`define RST_ADDR 24'h000000

// Other widths and values
`define ZERO_WORD 32'h00000000
`define ZERO_BITS2 2'h0
`define ZERO_BITS7 7'h00

`endif

//--- design/comm_ctrl_pkg.sv
// Types shared by the control register bank
// Assumes the power manager presents its status as one byte-shaped group
package comm_ctrl_pkg;

	typedef enum logic [1:0] {
		POWER_ACTIVE = 2'h0,
		POWER_DEEP_SLEEP = 2'h1,
		POWER_SHUT_DOWN = 2'h2,
		POWER_CLOCK_OFF = 2'h3
	} power_state_e;

	// Laid out exactly as the general status register
	typedef struct packed {
		logic [3:0] power_on_initial_condition;
		logic processor_reload_request;
		logic processor_subsystem_reset_held;
		power_state_e processor_power_state;
	} pm_status_s;

	typedef struct packed {
		logic dma_engine_reset_bit;
		logic dma_queue_flush;
		logic [23:0] start_address;
	} dma_ctrl_s;

endpackage

//--- tb/comm_ctrl_assertions.sv
// Concurrent checks on the control register bank ports
// Assumes binding onto comm_manager_control_regs by port name
`timescale 1ns/1ps
module comm_ctrl_checker (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Strobes and control
	input wire logic target_address_second_byte_wr_i,
	input wire logic transfer_length_high_byte_wr_i,
	input wire logic [1:0] transfer_length_low_byte_lsbs_i,
	input wire logic [1:0] bus_read_trigger_mode_o,
	input wire logic mem_read_start_o,
	input wire logic dma_kickoff_o,
	input wire comm_ctrl_pkg::dma_ctrl_s dma_ctrl_o
);
	wire wr = psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];
	wire tw = target_address_second_byte_wr_i;
	wire hw = transfer_length_high_byte_wr_i;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	property p_start;
		tw && bus_read_trigger_mode_o != 2'h3 |=> mem_read_start_o;
	endproperty
	a_start: assert property (p_start) else $error("no read start");
	property p_nostart;
		tw && bus_read_trigger_mode_o == 2'h3 |=> !mem_read_start_o;
	endproperty
	a_nostart: assert property (p_nostart) else $error("bad start");
	property p_kick;
		hw && transfer_length_low_byte_lsbs_i != 2'h2 |=>
			dma_kickoff_o == !dma_ctrl_o.dma_engine_reset_bit;
	endproperty
	a_kick: assert property (p_kick) else $error("no kickoff");
	property p_nokick;
		hw && transfer_length_low_byte_lsbs_i == 2'h2 |=> !dma_kickoff_o;
	endproperty
	a_nokick: assert property (p_nokick) else $error("bad kickoff");
	property p_lsb;
		dma_ctrl_o.start_address[1:0] == 2'h0;
	endproperty
	a_lsb: assert property (p_lsb) else $error("address lsbs set");
	property p_high;
		pready_o |-> prdata_o[31:8] == 24'h000000;
	endproperty
	a_high: assert property (p_high) else $error("upper read bits");
	property p_depth;
		pready_o && !pwrite_i && paddr_i == 8'hC0 |-> prdata_o[7:6] == 2'h0;
	endproperty
	a_depth: assert property (p_depth) else $error("depth code");
	property p_flush;
		wr && paddr_i == 8'hD8 |=> ##1
			dma_ctrl_o.dma_queue_flush == $past(pwdata_i[0], 2);
	endproperty
	a_flush: assert property (p_flush) else $error("flush bit");
	property p_eng;
		wr && paddr_i == 8'hDC |=> ##1
			dma_ctrl_o.dma_engine_reset_bit == $past(pwdata_i[0], 2);
	endproperty
	a_eng: assert property (p_eng) else $error("engine bit");
	c_start: cover property (tw ##1 mem_read_start_o);
	c_kick: cover property (hw ##1 dma_kickoff_o);
	c_err: cover property (pready_o && pslverr_o);
endmodule // comm_ctrl_checker
bind comm_manager_control_regs comm_ctrl_checker i_comm_ctrl_checker (.*);

//--- tb/pm_model.sv
// Power manager status source, registered on the bank clock
// Assumes the bench sets the wanted status value
`timescale 1ns/1ps
module pm_model (
	// Clock
	input wire logic clk_i,
	// Wanted and driven status
	input wire logic [7:0] val_i,
	output comm_ctrl_pkg::pm_status_s status_o
);
	always_ff @(posedge clk_i) begin
		status_o <= val_i;
	end
endmodule // pm_model

//--- tb/testbench.sv
// Self-checking bench for the control register bank
// Assumes the one-wait APB slave described for the bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
	logic mclk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [7:0] paddr_i = 8'h00, pm_val = 8'hE4;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic [3:0] pstrb_i = 4'hF;
	logic pready_o, pslverr_o, er, mem_read_start_o, dma_kickoff_o;
	logic target_address_second_byte_wr_i = 0;
	logic transfer_length_high_byte_wr_i = 0;
	logic [1:0] transfer_length_low_byte_lsbs_i = 2'h0, bus_read_trigger_mode_o;
	comm_ctrl_pkg::dma_ctrl_s dma_ctrl_o;
	comm_ctrl_pkg::pm_status_s pm_status_i;
	int err_total = 0, compares = 0;
	comm_manager_control_regs i_comm_manager_control_regs (.*);
	pm_model i_pm_model (.clk_i(mclk_i), .val_i(pm_val), .status_o(pm_status_i));
	initial forever #2.5 mclk_i = ~mclk_i;
	task summarize;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, d);
		int n;
		@(posedge mclk_i);
		psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= {24'h0, d};
		@(posedge mclk_i);
		penable_i <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk_i);
			if (pready_o === 1'b1) break;
		end
		if (n == 20) begin err_total++; summarize(); end
		rd = prdata_o; er = pslverr_o;
		psel_i <= 0; penable_i <= 0;
	endtask
	task automatic rdchk(input logic [7:0] a, d);
		apb(0, a, 8'h00);
		`CHK("read", {24'h0, d}, rd)
	endtask
	task automatic pulse(input logic k, input logic [1:0] l, input logic e);
		@(posedge mclk_i);
		transfer_length_low_byte_lsbs_i <= l;
		if (k) transfer_length_high_byte_wr_i <= 1;
		else target_address_second_byte_wr_i <= 1;
		@(posedge mclk_i);
		transfer_length_high_byte_wr_i <= 0;
		target_address_second_byte_wr_i <= 0;
		#1 `CHK("pulse", e, k ? dma_kickoff_o : mem_read_start_o)
	endtask
	task t_reset;
		rdchk(8'hC4, 8'h00);
		rdchk(8'hC0, 8'h00);
		rdchk(8'hE8, 8'h00);
		rdchk(8'hC8, 8'hE4);
	endtask
	task t_rw;
		apb(1, 8'hC4, 8'hA5);
		rdchk(8'hC4, 8'hA5);
		@(posedge mclk_i) pstrb_i <= 4'hE;
		apb(1, 8'hC4, 8'h00);
		pstrb_i <= 4'hF;
		apb(1, 8'hC5, 8'h77);
		`CHK("slverr", 1'b1, er)
		rdchk(8'hC4, 8'hA5);
		apb(1, 8'hC0, 8'hFD);
		rdchk(8'hC0, 8'h3D);
		apb(0, 8'hCC, 8'h00);
		`CHK("unmapped", 33'h100000000, {er, rd})
	endtask
	task t_mode;
		for (int m = 0; m < 4; m++) begin
			apb(1, 8'hC0, m[7:0]);
			#1 `CHK("mode", m[1:0], bus_read_trigger_mode_o)
			pulse(0, 2'h0, m != 3);
		end
	endtask
	task t_addr;
		apb(1, 8'hE0, 8'hFF);
		apb(1, 8'hE4, 8'h12);
		apb(1, 8'hE8, 8'h34);
		repeat (2) @(posedge mclk_i);
		`CHK("addr", 24'h3412FC, dma_ctrl_o.start_address)
		rdchk(8'hE0, 8'hFF);
	endtask
	task t_dma;
		apb(1, 8'hDC, 8'h01);
		rdchk(8'hDC, 8'h01);
		apb(1, 8'hD8, 8'hFF);
		rdchk(8'hD8, 8'h01);
		repeat (2) @(posedge mclk_i);
		`CHK("ctl", 2'h3, dma_ctrl_o[25:24])
		pulse(1, 2'h0, 0);
		apb(1, 8'hDC, 8'h00);
		apb(1, 8'hD8, 8'h00);
		repeat (2) @(posedge mclk_i);
		`CHK("ctl", 2'h0, dma_ctrl_o[25:24])
		pulse(1, 2'h0, 1);
		pulse(1, 2'h2, 0);
		pulse(1, 2'h3, 1);
	endtask
	task t_status;
		for (int p = 0; p < 4; p++) begin
			pm_val <= {6'h16, p[1:0]};
			repeat (8) @(posedge mclk_i);
			rdchk(8'hC8, {6'h16, p[1:0]});
		end
		apb(1, 8'hC8, 8'h00);
		rdchk(8'hC8, 8'h5B);
	endtask
	initial begin
		repeat (8) @(posedge mclk_i);
		resetn_i <= 1;
		t_reset();
		t_rw();
		t_mode();
		t_addr();
		t_dma();
		t_status();
		summarize();
	end
endmodule // testbench
